// ---- sps_pkg.sv ----
// Constants shared by the serial peripheral port design
package sps_pkg;
   // Control register field positions
   localparam int CTL_RATE_HI  = 7;
   localparam int CTL_ENABLE   = 6;
   localparam int CTL_SS_IGN   = 5;
   localparam int CTL_MASTER   = 4;
   localparam int CTL_IDLE_LVL = 3;
   localparam int CTL_PHASE    = 2;
   localparam int CTL_RATE_MID = 1;
   localparam int CTL_RATE_LO  = 0;
   localparam logic [7:0] CTL_RESET = 8'h14;
   // Status register field positions, unused bits read zero
   localparam int STA_DONE     = 7;
   localparam int STA_COLL     = 6;
   localparam int STA_FAULT    = 4;
   // Rate codes without a generator
   localparam logic [2:0] RATE_NONE_LO = 3'h0;
   localparam logic [2:0] RATE_NONE_HI = 3'h7;
   // Index of the last serial clock edge in a byte (two per bit) and of the last bit
   localparam logic [3:0] LAST_EDGE = 4'hf;
   localparam logic [2:0] LAST_BIT  = 3'h7;
endpackage : sps_pkg

// ---- sps_port.sv ----
// Serial peripheral port: master or slave byte shifter with control and status
`timescale 1ns/1ns
`default_nettype none

module sps_port
   import sps_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_sys_in,
   input  wire logic       sys_rst_in,
   // Software access
   input  wire logic       ctrl_wr_in,
   input  wire logic [7:0] ctrl_data_in,
   input  wire logic       data_wr_in,
   input  wire logic [7:0] data_in,
   input  wire logic       status_rd_in,
   input  wire logic       data_rd_in,
   output logic      [7:0] ctrl_out,
   output logic      [7:0] status_out,
   output logic      [7:0] rx_data_out,
   // Requests
   output logic            tx_irq_out,
   output logic            err_irq_out,
   // Serial clock pin
   input  wire logic       sck_in,
   output logic            sck_out,
   output logic            sck_oe_out,
   // Master out, slave in pin
   input  wire logic       mosi_in,
   output logic            mosi_out,
   output logic            mosi_oe_out,
   // Master in, slave out pin
   input  wire logic       miso_in,
   output logic            miso_out,
   output logic            miso_oe_out,
   // Slave select pin
   input  wire logic       ss_in
);

   // Whole register image; one clocked process copies it
   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] shift;
      logic [7:0] rx;
      logic       done;
      logic       coll;
      logic       fault;
      logic       arm_done;
      logic       arm_coll;
      logic       arm_fault;
      logic       busy;
      logic [3:0] edge_cnt;
      logic [2:0] bit_cnt;
      logic [6:0] div_cnt;
      logic       sck_prev;
      logic       ss_prev;
      logic       sck_o;
      logic       sck_oe;
      logic       mosi_o;
      logic       mosi_oe;
      logic       miso_o;
      logic       miso_oe;
      logic [7:0] status;
      logic       tx_irq;
      logic       err_irq;
   } sps_state_type;

   sps_state_type s;
   sps_state_type next_s;

   // Half of the serial clock period in system cycles, minus one
   function automatic logic [6:0] half_reload(input logic [2:0] code);
      logic [7:0] half;
      half = 8'h01 << code;
      return 7'(half - 8'h01);
   endfunction

   // Three rate bits are scattered over the control byte
   function automatic logic [2:0] rate_code(input logic [7:0] ctrl);
      return {ctrl[CTL_RATE_HI], ctrl[CTL_RATE_MID], ctrl[CTL_RATE_LO]};
   endfunction

   // Codes 0 and 7 have no generator behind them
   function automatic logic rate_valid(input logic [2:0] code);
      return (code != RATE_NONE_LO) && (code != RATE_NONE_HI);
   endfunction

   // A slave listens on a low select, or always with phase one and select ignored
   function automatic logic slave_selected(input logic       ss,
                                           input logic [7:0] ctrl);
      logic forced;
      forced = ctrl[CTL_PHASE] && ctrl[CTL_SS_IGN];
      return !ss || forced;
   endfunction

   // Serial clock and master out pins belong to the port only while it is an enabled master
   function automatic logic master_active(input logic [7:0] ctrl);
      return ctrl[CTL_ENABLE] && ctrl[CTL_MASTER];
   endfunction

   // An enabled slave drives its data pin only while selected
   function automatic logic slave_driving(input logic       ss,
                                          input logic [7:0] ctrl);
      return ctrl[CTL_ENABLE] && !ctrl[CTL_MASTER] && slave_selected(ss, ctrl);
   endfunction

   // Serial clock leaving its idle level
   function automatic logic leaves_idle(input logic prev,
                                        input logic now,
                                        input logic pol);
      return (prev == pol) && (now != pol);
   endfunction

   // Serial clock returning to its idle level
   function automatic logic returns_idle(input logic prev,
                                         input logic now,
                                         input logic pol);
      return (prev != pol) && (now == pol);
   endfunction

   // New bit enters at the bottom so the first bit ends up most significant
   function automatic logic [7:0] shift_in(input logic [7:0] shreg,
                                           input logic       din);
      return {shreg[6:0], din};
   endfunction

   // Status byte with unused bits reading zero
   function automatic logic [7:0] status_word(input logic done,
                                              input logic coll,
                                              input logic fault);
      logic [7:0] word;
      word            = 8'h00;
      word[STA_DONE]  = done;
      word[STA_COLL]  = coll;
      word[STA_FAULT] = fault;
      return word;
   endfunction

   logic       en;
   logic       mst;
   logic       clock_idle_level;
   logic       clock_sample_edge;
   logic       ss_ign;
   logic [2:0] rate;
   logic       rate_ok;
   logic       sel;
   logic       lead;
   logic       trail;
   logic       m_tick;
   logic       m_lead;

   always_comb begin
      next_s = s;
      en      = s.ctrl[CTL_ENABLE];
      mst     = s.ctrl[CTL_MASTER];
      clock_idle_level    = s.ctrl[CTL_IDLE_LVL];
      clock_sample_edge    = s.ctrl[CTL_PHASE];
      ss_ign  = s.ctrl[CTL_SS_IGN];
      rate    = rate_code(s.ctrl);
      rate_ok = rate_valid(rate);
      sel     = slave_selected(ss_in, s.ctrl);
      lead    = leaves_idle(s.sck_prev, sck_in, clock_idle_level);
      trail   = returns_idle(s.sck_prev, sck_in, clock_idle_level);
      m_tick  = 1'b0;
      m_lead  = 1'b0;
      next_s.sck_prev = sck_in;
      next_s.ss_prev  = ss_in;

      // Clearing sequences; hardware sets below take priority
      if (status_rd_in) begin
         next_s.arm_done  = s.done;
         next_s.arm_coll  = 1'b1;
         next_s.arm_fault = s.fault;
      end
      if (data_rd_in && s.arm_done) begin
         next_s.done     = 1'b0;
         next_s.arm_done = 1'b0;
      end
      if ((data_rd_in || data_wr_in) && s.arm_coll) begin
         next_s.coll     = 1'b0;
         next_s.arm_coll = 1'b0;
      end
      if (ctrl_wr_in) begin
         next_s.ctrl = ctrl_data_in;
         if (s.arm_fault) begin
            next_s.fault     = 1'b0;
            next_s.arm_fault = 1'b0;
         end
      end

      // Data write: load when idle, flag collision otherwise
      if (data_wr_in) begin
         if (s.busy) begin
            next_s.coll = 1'b1;
         end else begin
            next_s.shift = data_in;
            if (en && mst) begin
               next_s.busy     = 1'b1;
               next_s.edge_cnt = 4'h0;
               next_s.div_cnt  = half_reload(rate);
               if (!clock_sample_edge) begin
                  next_s.mosi_o = data_in[7];
               end
            end else if (en && !clock_sample_edge && sel) begin
               next_s.miso_o = data_in[7];
            end
         end
      end

      if (!en) begin
         next_s.busy    = 1'b0;
         next_s.bit_cnt = 3'h0;
         next_s.sck_o   = clock_idle_level;
      end else if (mst) begin
         // Master: divider gives one enable per serial clock half period
         if (!s.busy) begin
            next_s.sck_o = clock_idle_level;
         end else if (rate_ok) begin
            if (s.div_cnt == 7'h00) begin
               m_tick = 1'b1;
               next_s.div_cnt = half_reload(rate);
            end else begin
               next_s.div_cnt = s.div_cnt - 7'h01;
            end
         end
         if (m_tick) begin
            m_lead       = !s.edge_cnt[0];
            next_s.sck_o = !s.sck_o;
            if (m_lead != clock_sample_edge) begin
               next_s.shift = shift_in(s.shift, miso_in);
            end else begin
               next_s.mosi_o = s.shift[7];
            end
            next_s.edge_cnt = s.edge_cnt + 4'h1;
            if (s.edge_cnt == LAST_EDGE) begin
               next_s.busy = 1'b0;
               next_s.done = 1'b1;
               next_s.rx   = next_s.shift;
            end
         end
         // Low select while master means another master is on the bus
         // An abort leaves the half shifted byte in place; done stays clear
         if (!ss_in && !ss_ign) begin
            next_s.fault = 1'b1;
            next_s.ctrl[CTL_ENABLE] = 1'b0;
            next_s.ctrl[CTL_MASTER] = 1'b0;
            next_s.busy  = 1'b0;
            next_s.sck_o = clock_idle_level;
         end
      end else begin
         // Slave: serial clock taken as synchronous, needs slow edges
         // Deselecting restarts the bit count, so a cut byte is thrown away
         if (!sel) begin
            next_s.busy    = 1'b0;
            next_s.bit_cnt = 3'h0;
         end else begin
            if (!clock_sample_edge && s.ss_prev && !ss_in) begin
               next_s.busy   = 1'b1;
               next_s.miso_o = s.shift[7];
            end
            if (clock_sample_edge ? trail : lead) begin
               next_s.shift   = shift_in(s.shift, mosi_in);
               next_s.bit_cnt = s.bit_cnt + 3'h1;
               if (s.bit_cnt == LAST_BIT) begin
                  next_s.rx   = next_s.shift;
                  next_s.done = 1'b1;
                  next_s.busy = 1'b0;
               end
            end
            if (clock_sample_edge ? lead : trail) begin
               next_s.miso_o = s.shift[7];
               if (clock_sample_edge) begin
                  next_s.busy = 1'b1;
               end
            end
         end
      end

      // Pin drive and registered views
      next_s.sck_oe  = master_active(next_s.ctrl);
      next_s.mosi_oe = next_s.sck_oe;
      next_s.miso_oe = slave_driving(ss_in, next_s.ctrl);
      next_s.status  = status_word(next_s.done, next_s.coll, next_s.fault);
      next_s.tx_irq  = next_s.done;
      next_s.err_irq = next_s.fault && !next_s.ctrl[CTL_SS_IGN];
   end

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         s          <= '0;
         s.ctrl     <= CTL_RESET;
         s.sck_prev <= CTL_RESET[CTL_IDLE_LVL];
         s.ss_prev  <= 1'b1;
         s.sck_o    <= CTL_RESET[CTL_IDLE_LVL];
      end else begin
         s <= next_s;
      end
   end

   assign ctrl_out    = s.ctrl;
   assign status_out  = s.status;
   assign rx_data_out = s.rx;
   assign tx_irq_out  = s.tx_irq;
   assign err_irq_out = s.err_irq;
   assign sck_out     = s.sck_o;
   assign sck_oe_out  = s.sck_oe;
   assign mosi_out    = s.mosi_o;
   assign mosi_oe_out = s.mosi_oe;
   assign miso_out    = s.miso_o;
   assign miso_oe_out = s.miso_oe;

endmodule // sps_port

`default_nettype wire

// ---- sps_checker.sv ----
// Concurrent property checker for the serial peripheral port pins
`timescale 1ns/1ns
`default_nettype none
module sps_checker
   import sps_pkg::*;
(
   // Clock, reset, strobes and slave select
   input wire logic       clk_sys_in,
   input wire logic       sys_rst_in,
   input wire logic       ctrl_wr_in,
   input wire logic       data_rd_in,
   input wire logic       ss_in,
   // Observed outputs
   input wire logic [7:0] ctrl_out,
   input wire logic [7:0] status_out,
   input wire logic       tx_irq_out,
   input wire logic       err_irq_out,
   input wire logic       sck_out,
   input wire logic       sck_oe_out,
   input wire logic       miso_oe_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (sys_rst_in);
   logic [4:0] edges;
   logic       last_sck;
   logic       mst;
   assign mst = ctrl_out[CTL_MASTER] && ctrl_out[CTL_ENABLE];
   // A polarity write moves sck without a real edge, so it restarts the count
   always_ff @(posedge clk_sys_in) begin
      last_sck <= sck_out;
      if (sys_rst_in || !sck_oe_out || ctrl_wr_in || $past(ctrl_wr_in))
         edges <= 5'h0;
      else if ($rose(status_out[STA_DONE]))
         edges <= 5'h0;
      else if (sck_out != last_sck)
         edges <= edges + 5'h1;
   end
   a_eight_cycles: assert property ($rose(status_out[STA_DONE]) && mst |->
      edges + 5'(sck_out != last_sck) == 5'h10) else $error("sck edge count wrong");
   a_idle_level: assert property ($rose(status_out[STA_DONE]) && mst |->
      sck_out == ctrl_out[CTL_IDLE_LVL]) else $error("sck not at idle level");
   a_miso_off: assert property (!ctrl_out[CTL_MASTER] && ss_in && !ctrl_wr_in &&
      !(ctrl_out[CTL_PHASE] && ctrl_out[CTL_SS_IGN]) |=> !miso_oe_out) else $error("miso driven");
   a_done_keep: assert property (status_out[STA_DONE] && !data_rd_in |=>
      status_out[STA_DONE]) else $error("done flag lost");
   a_fault_keep: assert property (status_out[STA_FAULT] && !ctrl_wr_in |=>
      status_out[STA_FAULT]) else $error("fault flag lost");
   a_fault_set: assert property (mst && !ctrl_out[CTL_SS_IGN] && !ss_in && !ctrl_wr_in
      |-> ##[1:2] status_out[STA_FAULT]) else $error("fault not raised");
   a_fault_stop: assert property ($rose(status_out[STA_FAULT]) |-> ##[0:1]
      (!ctrl_out[CTL_ENABLE] && !ctrl_out[CTL_MASTER]) ##[0:1] err_irq_out) else $error("no stop");
   a_fault_masked: assert property (mst && ctrl_out[CTL_SS_IGN] && !ctrl_wr_in |=>
      !$rose(status_out[STA_FAULT])) else $error("fault while ignored");
   a_tx_request: assert property (status_out[STA_DONE] |-> ##[0:1] tx_irq_out)
      else $error("no transmit request");
   c_master_done: cover property ($rose(status_out[STA_DONE]) && mst);
   c_slave_done: cover property ($rose(status_out[STA_DONE]) && !ctrl_out[CTL_MASTER]);
   c_fault: cover property ($rose(status_out[STA_FAULT]));
   c_collision: cover property ($rose(status_out[STA_COLL]));
endmodule // sps_checker
bind sps_port sps_checker sps_checker_inst (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
   .ctrl_wr_in(ctrl_wr_in), .data_rd_in(data_rd_in), .ss_in(ss_in), .ctrl_out(ctrl_out),
   .status_out(status_out), .tx_irq_out(tx_irq_out), .err_irq_out(err_irq_out),
   .sck_out(sck_out), .sck_oe_out(sck_oe_out), .miso_oe_out(miso_oe_out));
`default_nettype wire

// ---- sps_far_slave.sv ----
// Behavioural slave device at the far end of the master link
`timescale 1ns/1ns
`default_nettype none
module sps_far_slave (
   // Select and configuration
   input  wire logic       sel_n_in,
   input  wire logic       pol_in,
   input  wire logic       pha_in,
   input  wire logic [7:0] tx_in,
   // Serial lines
   input  wire logic       sck_in,
   input  wire logic       mosi_in,
   output logic            miso_out,
   output logic      [7:0] rx_out
);
   logic [7:0] shreg;
   logic       first;
   // Released line shows the inverted bit so a stale value cannot pass
   assign miso_out = sel_n_in ? ~shreg[7] : shreg[7];
   always @(negedge sel_n_in) begin
      shreg = tx_in;
      first = 1'b1;
   end
   always @(sck_in) begin
      if (!sel_n_in && ((sck_in != pol_in) ^ pha_in))
         rx_out = {rx_out[6:0], mosi_in};
      else if (!sel_n_in && pha_in && first)
         first = 1'b0;
      else if (!sel_n_in)
         shreg = {shreg[6:0], 1'b0};
   end
endmodule // sps_far_slave
`default_nettype wire

// ---- test_sps_port.sv ----
// Self-checking bench for the serial peripheral port
`timescale 1ns/1ns
`default_nettype none
module test_sps_port
   import sps_pkg::*;
;
   logic       clk_sys_in = 1'b0;
   logic       sys_rst_in = 1'b1;
   logic       ctrl_wr_in = 1'b0, data_wr_in = 1'b0, status_rd_in = 1'b0, data_rd_in = 1'b0;
   logic [7:0] ctrl_data_in = 8'h00, data_in = 8'h00, slv_tx = 8'h00, cfg;
   logic       ss_in = 1'b1, ext_sck = 1'b0, ext_mosi = 1'b0, sel_n = 1'b1, pol = 1'b0, pha = 1'b0;
   wire logic [7:0] ctrl_out, status_out, rx_data_out, far_rx;
   wire logic       tx_irq_out, err_irq_out, sck_out, sck_oe_out, mosi_out, mosi_oe_out;
   wire logic       miso_out, miso_oe_out, far_miso;
   wire logic       sck_w = sck_oe_out ? sck_out : ext_sck;
   wire logic       mosi_w = mosi_oe_out ? mosi_out : ext_mosi;
   wire logic       miso_w = miso_oe_out ? miso_out : far_miso;
   int              checks = 0;
   int              bad_count = 0;
   always #20 clk_sys_in = ~clk_sys_in;
   sps_port sps_port_inst (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
      .ctrl_wr_in(ctrl_wr_in), .ctrl_data_in(ctrl_data_in), .data_wr_in(data_wr_in),
      .data_in(data_in), .status_rd_in(status_rd_in), .data_rd_in(data_rd_in),
      .ctrl_out(ctrl_out), .status_out(status_out), .rx_data_out(rx_data_out),
      .tx_irq_out(tx_irq_out), .err_irq_out(err_irq_out), .sck_in(sck_w), .sck_out(sck_out),
      .sck_oe_out(sck_oe_out), .mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe_out(mosi_oe_out),
      .miso_in(miso_w), .miso_out(miso_out), .miso_oe_out(miso_oe_out), .ss_in(ss_in));
   sps_far_slave sps_far_slave_inst (.sel_n_in(sel_n), .pol_in(pol), .pha_in(pha),
      .tx_in(slv_tx), .sck_in(sck_w), .mosi_in(mosi_w), .miso_out(far_miso), .rx_out(far_rx));
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys_in);
      #2;
   endtask
   task automatic pulse(ref logic strobe);
      strobe = 1'b1;
      tick(1);
      strobe = 1'b0;
   endtask
   task automatic ctl(input logic [7:0] v);
      ctrl_data_in = v;
      pulse(ctrl_wr_in);
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic mxfer(input logic [7:0] tx, input logic [7:0] stx, input int h, input bit coll);
      int n;
      slv_tx = stx;
      sel_n = 1'b0;
      data_in = tx;
      pulse(data_wr_in);
      n = 0;
      if (coll) begin
         tick(1);
         data_in = ~tx;
         pulse(data_wr_in);
         n = 2;
      end
      while (status_out[STA_DONE] !== 1'b1 && n < 4000) begin
         tick(1);
         n++;
      end
      chk(8'(n >= 16 * h - 1 && n <= 16 * h + 2), 8'h01, "rate");
      chk(rx_data_out, stx, "master rx");
      chk(far_rx, tx, "far rx");
      chk(status_out & 8'hc0, {1'b1, coll, 6'h00}, "flags");
      pulse(data_rd_in);
      chk(status_out & 8'h80, 8'h80, "done kept");
      pulse(status_rd_in);
      pulse(data_rd_in);
      chk(status_out & 8'hc0, 8'h00, "flags cleared");
      sel_n = 1'b1;
   endtask
   task automatic sxfer(input logic [7:0] mo, input logic [7:0] exp);
      logic [7:0] got;
      for (int i = 7; i >= 0; i--) begin
         ext_sck = 1'b1;
         ext_mosi = mo[i];
         tick(3);
         got[i] = miso_w;
         ext_sck = 1'b0;
         tick(3);
      end
      ext_mosi = ~ext_mosi;
      tick(2);
      chk(got, exp, "slave out");
      chk(rx_data_out, mo, "slave rx");
      chk(status_out & 8'h80, 8'h80, "slave done");
      pulse(status_rd_in);
      pulse(data_rd_in);
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      tick(12);
      sys_rst_in = 1'b0;
      chk(ctrl_out, CTL_RESET, "ctrl reset");
      chk(status_out | rx_data_out, 8'h00, "status reset");
      $display("test reset finished");
      for (int c = 1; c < 7; c++) begin
         cfg = {c[2], 1'b0, 2'b11, c[0], c[1], c[1:0]};
         pol = c[0];
         pha = c[1];
         ctl(cfg);
         tick(1);
         ctl(cfg | 8'h40);
         mxfer(8'ha5 ^ 8'(c), 8'h3c + 8'(c), 1 << c, c == 3);
         chk({7'h00, sck_w}, {7'h00, pol}, "idle level");
      end
      $display("test master finished");
      ctl(8'h51);
      ss_in = 1'b0;
      tick(2);
      ss_in = 1'b1;
      chk(status_out & 8'h10, 8'h10, "fault");
      chk(ctrl_out & 8'h50, 8'h00, "fault stop");
      chk({7'h00, err_irq_out}, 8'h01, "error request");
      ctl(8'h31);
      tick(1);
      ctl(8'h11);
      chk(status_out & 8'h10, 8'h10, "fault kept");
      pulse(status_rd_in);
      ctl(8'h31);
      tick(1);
      ctl(8'h71);
      ss_in = 1'b0;
      tick(3);
      ss_in = 1'b1;
      chk(status_out & 8'h10, 8'h00, "fault masked");
      $display("test fault finished");
      ctl(8'h04);
      tick(1);
      ctl(8'h44);
      data_in = 8'h96;
      pulse(data_wr_in);
      chk({7'h00, miso_oe_out}, 8'h00, "miso released");
      ss_in = 1'b0;
      sxfer(8'h5a, 8'h96);
      sxfer(8'hc3, 8'h5a);
      ss_in = 1'b1;
      ctl(8'h64);
      sxfer(8'h0f, 8'hc3);
      ctl(8'h00);
      tick(1);
      ctl(8'h40);
      data_in = 8'h3c;
      pulse(data_wr_in);
      ss_in = 1'b0;
      tick(2);
      sxfer(8'h81, 8'h3c);
      ss_in = 1'b1;
      $display("test slave finished");
      report_and_stop();
   end
   // About 2300 cycles are needed; allow several times that before giving up
   initial begin
      #600000;
      bad_count++;
      report_and_stop();
   end
endmodule // test_sps_port
`default_nettype wire
